// >>> hw/priority_interrupt_controller.v
// priority interrupt controller with exception sequencer and wishbone register slave
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
`include "pic_consts.vh"

module priority_interrupt_controller (
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  // wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // request sources
  input  wire [15:0] src_event,
  input  wire        nmi_event,
  // core execution status
  input  wire        insn_end,
  input  wire [15:0] resume_pc,
  // stack push port
  output reg         stack_we,
  output reg  [15:0] stack_data,
  // vector table read port
  output reg         vec_rd,
  output reg  [15:0] vec_addr,
  input  wire        vec_ack,
  input  wire [15:0] vec_data,
  // handler hand-off
  output reg  [15:0] handler_pc,
  output reg         handler_valid,
  output reg         irq_accept,
  output reg  [7:0]  accept_vector
);

  // register map, one 32-bit word per offset:
  //   mode    - bits 1:0 select fixed order (0) or level mode (2)
  //   enable  - one bit per source; a disabled source never becomes pending
  //   levels  - a 3-bit level per module, a nibble each, top bit of each nibble reads 0
  //   cc      - bit 7 is the global mask used in fixed-order mode
  //   xstat   - bit 7 trace, bits 2:0 mask level used in level mode
  //   status  - read only: pending sources, nonmaskable flag, sequencer busy
  //   vector  - read only: last vector number and the handler address fetched for it
  // unmapped offsets still answer, read as zero and drop writes
  //
  // acceptance and exception sequence:
  //   idle  - the arbiter result is taken when the current masks allow it
  //   wait  - the running instruction is allowed to finish first
  //   push  - resume address, condition codes and, in level mode, extended status
  //   fetch - vector table read, held until the core answers it
  //   done  - handler address handed over, then back to idle
  // the mode latched at acceptance steers the whole sequence, so a mode
  // write during a sequence only affects the next acceptance
  //
  // arbitration:
  //   sources are scanned from index 0 upwards; a later source only wins
  //   with a strictly higher level, so equal levels fall back to the
  //   default order where the smaller vector number ranks first
  //   in fixed-order mode every level reads as zero, which leaves only
  //   the default order
  //   two neighbouring sources share one module level field
  //   the nonmaskable flag overrides both masks and the scan result
  //
  // timing:
  //   a source event is registered one edge before the arbiter sees it
  //   bus answers come one cycle after the request is taken
  //
  // hazards and limits:
  //   the pushed mask state is the value before acceptance; the mask is
  //   rewritten in the cycle of the last push, and a software write to the
  //   same register in that cycle is lost
  //   pending is not cleared by acceptance: a source must drop its event
  //   itself, or the raised mask keeps it from being taken twice
  //   a nonmaskable edge arriving while the flag is cleared keeps the flag set
  //   at least one idle cycle separates two acceptances
  //   the vector read data must stay valid until the handler pulse

  // sequencer states, one-hot
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_WAIT  = 5'h02;
  localparam [4:0] S_PUSH  = 5'h04;
  localparam [4:0] S_FETCH = 5'h08;
  localparam [4:0] S_DONE  = 5'h10;

  // software-visible state
  reg [1:0]               op_mode;
  reg [`NSRC-1:0]         src_enable;
  reg [31:0]              prio_levels;
  reg [7:0]               cc_reg;
  reg [7:0]               ext_status;

  // request and sequencer state
  reg [`NSRC-1:0]         pending;
  reg                     nmi_prev;
  reg                     nmi_flag;
  reg [4:0]               state;
  reg [1:0]               push_step;
  reg                     acc_level_mode;
  reg                     acc_nmi;
  reg [`LVLW-1:0]         acc_level;
  reg [7:0]               acc_vector;
  reg [7:0]               last_vector;

  // arbitration results
  reg                     best_hit;
  reg [3:0]               best_idx;
  reg [`LVLW-1:0]         best_lvl;
  reg                     win_ok;
  reg [`LVLW-1:0]         lvl_i;
  integer                 i;

  // bus helpers
  wire                    bus_req;
  wire                    bus_wr;
  wire [31:0]             wmask;
  wire                    seq_cc_update;
  wire [`NSRC*`LVLW-1:0]  src_lvl;
  wire                    mode_level;
  wire                    nmi_rise;
  wire [31:0]             mode_wr;

  assign bus_req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr        = bus_req & wb_we_i;
  assign wmask         = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign mode_level    = (op_mode == `MODE_LEVEL);
  assign nmi_rise      = nmi_event & ~nmi_prev;
  assign mode_wr       = ({30'h00000000, op_mode} & ~wmask) | (wb_dat_i & wmask);
  // last push cycle is where the mask state is rewritten
  assign seq_cc_update = (state == S_PUSH) &&
                         (push_step == (acc_level_mode ? 2'h2 : 2'h1));

  // each source takes the level field of its module; two sources per module
  genvar g;
  generate
    for (g = 0; g < `NSRC; g = g + 1) begin : g_lvl
      assign src_lvl[g*`LVLW +: `LVLW] = prio_levels[(g/2)*4 +: `LVLW];
    end
  endgenerate

  // pick the winning pending source and decide if it may be taken now
  always @* begin
    best_hit = 1'b0;
    best_idx = 4'h0;
    best_lvl = {`LVLW{1'b0}};
    lvl_i    = {`LVLW{1'b0}};
    // ascending scan: lower index (smaller vector) wins unless strictly higher level
    for (i = 0; i < `NSRC; i = i + 1) begin
      lvl_i = mode_level ? src_lvl[i*`LVLW +: `LVLW] : {`LVLW{1'b0}};
      if (pending[i] && (!best_hit || lvl_i > best_lvl)) begin
        best_hit = 1'b1;
        best_idx = i[3:0];
        best_lvl = lvl_i;
      end
    end
    if (nmi_flag) begin
      win_ok = 1'b1;
    end else if (mode_level) begin
      win_ok = best_hit && (best_lvl > ext_status[`LVLW-1:0]);
    end else begin
      win_ok = best_hit && !cc_reg[`CC_MASK_BIT];
    end
  end

  // source requests are re-sampled each cycle through their enables
  always @(posedge clk) begin
    if (srst) begin
      pending  <= `RST_ENABLE;
      nmi_prev <= 1'b0;
    end else begin
      pending  <= src_event & src_enable;
      nmi_prev <= nmi_event;
    end
  end

  // nonmaskable flag: a new edge wins over the clear on acceptance
  always @(posedge clk) begin
    if (srst) begin
      nmi_flag <= 1'b0;
    end else if (nmi_rise) begin
      nmi_flag <= 1'b1;
    end else if (state == S_IDLE && nmi_flag) begin
      nmi_flag <= 1'b0;
    end
  end

  // exception sequencer
  always @(posedge clk) begin
    if (srst) begin
      state          <= S_IDLE;
      push_step      <= 2'h0;
      acc_level_mode <= 1'b0;
      acc_nmi        <= 1'b0;
      acc_level      <= {`LVLW{1'b0}};
      acc_vector     <= 8'h00;
      last_vector    <= 8'h00;
      stack_we       <= 1'b0;
      stack_data     <= 16'h0000;
      vec_rd         <= 1'b0;
      vec_addr       <= 16'h0000;
      handler_pc     <= 16'h0000;
      handler_valid  <= 1'b0;
      irq_accept     <= 1'b0;
      accept_vector  <= 8'h00;
    end else begin
      stack_we      <= 1'b0;
      handler_valid <= 1'b0;
      irq_accept    <= 1'b0;
      case (state)
        S_IDLE: begin
          if (win_ok) begin
            acc_level_mode <= mode_level;
            acc_nmi        <= nmi_flag;
            acc_level      <= nmi_flag ? `NMI_LEVEL : best_lvl;
            acc_vector     <= nmi_flag ? `NMI_VECTOR : (`SRC_VEC_BASE + {4'h0, best_idx});
            accept_vector  <= nmi_flag ? `NMI_VECTOR : (`SRC_VEC_BASE + {4'h0, best_idx});
            irq_accept     <= 1'b1;
            state          <= S_WAIT;
          end
        end
        S_WAIT: begin
          // running instruction completes before any push
          if (insn_end) begin
            push_step <= 2'h0;
            state     <= S_PUSH;
          end
        end
        S_PUSH: begin
          stack_we <= 1'b1;
          case (push_step)
            2'h0:    stack_data <= resume_pc;
            2'h1:    stack_data <= {8'h00, cc_reg};
            default: stack_data <= {8'h00, ext_status};
          endcase
          if (seq_cc_update) begin
            state <= S_FETCH;
          end else begin
            push_step <= push_step + 2'h1;
          end
        end
        S_FETCH: begin
          // vector entry address is four bytes per vector number
          vec_rd   <= 1'b1;
          vec_addr <= {6'h00, acc_vector, 2'h0};
          if (vec_rd && vec_ack) begin
            vec_rd <= 1'b0;
            state  <= S_DONE;
          end
        end
        S_DONE: begin
          handler_pc    <= vec_data;
          handler_valid <= 1'b1;
          last_vector   <= acc_vector;
          state         <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // handler data is captured in the fetch cycle the read is acknowledged
  reg [15:0] fetched;
  always @(posedge clk) begin
    if (srst) begin
      fetched <= 16'h0000;
    end else if (state == S_FETCH && vec_rd && vec_ack) begin
      fetched <= vec_data;
    end
  end

  // configuration registers written by software
  always @(posedge clk) begin
    if (srst) begin
      op_mode     <= `RST_MODE;
      src_enable  <= `RST_ENABLE;
      prio_levels <= `RST_LEVELS;
    end else if (bus_wr) begin
      case (wb_adr_i)
        `ADR_MODE: begin
          // only the two defined modes are taken, anything else is ignored
          if (mode_wr[1:0] == `MODE_FIXED || mode_wr[1:0] == `MODE_LEVEL) begin
            op_mode <= mode_wr[1:0];
          end
        end
        `ADR_ENABLE: begin
          src_enable <= (src_enable & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        end
        `ADR_LEVELS: begin
          prio_levels <= ((prio_levels & ~wmask) | (wb_dat_i & wmask)) & 32'h77777777;
        end
        default: begin
          op_mode <= op_mode;
        end
      endcase
    end
  end

  // core mask state: the sequencer update has priority over software
  always @(posedge clk) begin
    if (srst) begin
      cc_reg     <= `RST_CC;
      ext_status <= `RST_XSTAT;
    end else if (seq_cc_update) begin
      if (acc_level_mode) begin
        ext_status[`XS_TRACE_BIT] <= 1'b0;
        ext_status[`LVLW-1:0]     <= acc_nmi ? `NMI_LEVEL : acc_level;
      end else begin
        cc_reg[`CC_MASK_BIT] <= 1'b1;
      end
    end else if (bus_wr && wb_adr_i == `ADR_CC && wb_sel_i[0]) begin
      cc_reg <= wb_dat_i[7:0];
    end else if (bus_wr && wb_adr_i == `ADR_XSTAT && wb_sel_i[0]) begin
      ext_status <= wb_dat_i[7:0] & 8'h87;
    end
  end

  // wishbone answer: ack one cycle after the request, dropped the next
  always @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h00000000;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          `ADR_MODE:   wb_dat_o <= {30'h00000000, op_mode};
          `ADR_ENABLE: wb_dat_o <= {16'h0000, src_enable};
          `ADR_LEVELS: wb_dat_o <= prio_levels;
          `ADR_CC:     wb_dat_o <= {24'h000000, cc_reg};
          `ADR_XSTAT:  wb_dat_o <= {24'h000000, ext_status};
          `ADR_STATUS: wb_dat_o <= {14'h0000, (state != S_IDLE), nmi_flag, pending};
          `ADR_VECTOR: wb_dat_o <= {8'h00, fetched, last_vector};
          default:     wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// >>> hw/pic_consts.vh
// constants, register map and field layout of the priority interrupt controller
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH

// source structure
`define NSRC            16
`define NMOD            8
`define LVLW            3

// operating modes
`define MODE_FIXED      2'h0
`define MODE_LEVEL      2'h2

// register byte addresses
`define ADR_MODE        8'h00
`define ADR_ENABLE      8'h04
`define ADR_LEVELS      8'h08
`define ADR_CC          8'h0C
`define ADR_XSTAT       8'h10
`define ADR_STATUS      8'h14
`define ADR_VECTOR      8'h18

// field positions
`define CC_MASK_BIT     7
`define XS_TRACE_BIT    7
`define ST_NMI_BIT      16
`define ST_BUSY_BIT     17

// vectors and levels
`define NMI_VECTOR      8'h07
`define SRC_VEC_BASE    8'h10
`define NMI_LEVEL       3'h7

// reset values
`define RST_MODE        2'h0
`define RST_ENABLE      16'h0000
`define RST_LEVELS      32'h77777777
`define RST_CC          8'h80
`define RST_XSTAT       8'h07

`endif

// >>> dv/pic_core_model.sv
// core model: ends instructions and answers vector table reads
`timescale 1ns/1ns
module pic_core_model (
  // clock and reset
  input  logic        clk,
  input  logic        srst,
  // controller side
  input  logic        vec_rd,
  input  logic [15:0] vec_addr,
  input  logic        handler_valid,
  // core answers
  output logic        insn_end,
  output logic        vec_ack,
  output logic [15:0] vec_data
);
  logic [1:0] phase;
  // an instruction ends every fourth cycle; reads are answered on odd phases only
  always @(posedge clk) begin
    if (srst) begin
      phase    <= 2'h0;
      insn_end <= 1'b0;
      vec_ack  <= 1'b0;
      vec_data <= 16'hFFFF;
    end else begin
      phase    <= phase + 2'h1;
      insn_end <= phase == 2'h3;
      vec_ack  <= vec_rd && !vec_ack && phase[0];
      if (vec_rd && !vec_ack && phase[0])
        vec_data <= 16'hC000 | vec_addr;
      else if (handler_valid)
        vec_data <= ~vec_data; // stale once consumed
    end
  end
endmodule

// >>> dv/pic_assertions.sv
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ns
module pic_assertions (
  // clock, reset and bus
  input logic        clk,
  input logic        srst,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_ack_o,
  input logic [31:0] wb_dat_o,
  // requests and core side
  input logic        nmi_event,
  input logic        insn_end,
  input logic        stack_we,
  input logic        vec_rd,
  input logic [15:0] vec_addr,
  input logic        vec_ack,
  input logic [15:0] vec_data,
  input logic [15:0] handler_pc,
  input logic        handler_valid,
  input logic        irq_accept,
  input logic [7:0]  accept_vector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // the two steps of the vector fetch
  sequence s_fetch;
    vec_rd && vec_ack;
  endsequence
  sequence s_handoff;
    handler_valid && handler_pc == vec_data;
  endsequence
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data leak");
  a_vec_addr: assert property (vec_rd |-> vec_addr == {6'h00, accept_vector, 2'h0})
    else $error("wrong vector address");
  a_rd_held: assert property (vec_rd && !vec_ack |=> vec_rd && $stable(vec_addr))
    else $error("vector read dropped");
  a_fetch_handoff: assert property (s_fetch |-> ##[1:2] s_handoff)
    else $error("handler not taken from table");
  a_push_after_end: assert property (stack_we && !$past(stack_we) |-> $past(insn_end, 2))
    else $error("push before instruction end");
  a_accept_gap: assert property (irq_accept |=> !irq_accept [*4])
    else $error("acceptance during sequence");
  a_nmi_taken: assert property ($rose(nmi_event) |->
    ##[1:60] (irq_accept && accept_vector == 8'h07))
    else $error("nonmaskable request not accepted");
  a_valid_pulse: assert property (handler_valid |=> !handler_valid) else $error("valid too long");
endmodule
bind priority_interrupt_controller pic_assertions u_chk (.clk, .srst, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_dat_o, .nmi_event, .insn_end, .stack_we, .vec_rd, .vec_addr, .vec_ack,
  .vec_data, .handler_pc, .handler_valid, .irq_accept, .accept_vector);

// >>> dv/priority_interrupt_controller_test.sv
// self-checking bench for the priority interrupt controller
`timescale 1ns/1ns
`include "pic_consts.vh"
module priority_interrupt_controller_test;
  typedef struct {
    logic [1:0] md;
    logic [7:0] cc, xs;
    logic [31:0] lv;
    logic [15:0] en, src;
    logic nmi, acc;
    logic [7:0] vec, post;
  } row_t;
  logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, nmi = 0, hdone = 0;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0;
  logic [15:0] src = 0;
  logic [31:0] rdat;
  logic ack, sw, rd, va, ie, acc, hv;
  logic [15:0] sd, vad, vd, hpc, seen_pc;
  logic [7:0] av;
  logic [15:0] pushes[$];
  int nacc, miscompares, num_checks;
  row_t rows[9] = '{
    '{2'h0, 8'h00, 8'h07, 32'h70, 16'hFFFF, 16'h0006, 0, 1, 8'h11, 8'h80},
    '{2'h0, 8'h80, 8'h07, 32'h0, 16'hFFFF, 16'h0001, 0, 0, 8'h00, 8'h80},
    '{2'h0, 8'h80, 8'h07, 32'h0, 16'hFFFF, 16'h0000, 1, 1, 8'h07, 8'h80},
    '{2'h0, 8'h00, 8'h07, 32'h0, 16'h0000, 16'h0001, 0, 0, 8'h00, 8'h00},
    '{2'h2, 8'h80, 8'h02, 32'h370, 16'hFFFF, 16'h0015, 0, 1, 8'h12, 8'h07},
    '{2'h2, 8'h00, 8'h83, 32'h33, 16'hFFFF, 16'h000C, 0, 0, 8'h00, 8'h83},
    '{2'h2, 8'h00, 8'h82, 32'h33, 16'hFFFF, 16'h000A, 0, 1, 8'h11, 8'h03},
    '{2'h2, 8'h00, 8'h87, 32'h33, 16'hFFFF, 16'h0000, 1, 1, 8'h07, 8'h07},
    '{2'h2, 8'h00, 8'h00, 32'h0, 16'hFFFF, 16'h0001, 0, 0, 8'h00, 8'h00}};
  priority_interrupt_controller DUT (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .src_event(src), .nmi_event(nmi), .insn_end(ie), .resume_pc(16'h2468),
    .stack_we(sw), .stack_data(sd), .vec_rd(rd), .vec_addr(vad), .vec_ack(va), .vec_data(vd),
    .handler_pc(hpc), .handler_valid(hv), .irq_accept(acc), .accept_vector(av));
  pic_core_model core (.clk(clk), .srst(srst), .vec_rd(rd), .vec_addr(vad),
    .handler_valid(hv), .insn_end(ie), .vec_ack(va), .vec_data(vd));
  // clock at 100 ns
  initial forever #50 clk = ~clk;
  // record acceptances, pushed words and handler hand-offs
  always @(posedge clk) begin
    if (acc === 1'b1) nacc <= nacc + 1;
    if (sw === 1'b1) pushes.push_back(sd);
    if (hv === 1'b1) begin
      seen_pc <= hpc;
      hdone <= 1'b1;
    end
  end
  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (ack !== 1'b1) miscompares++; // a bus request left unanswered is a failure
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task wait_done;
    for (int n = 0; n < 60 && !hdone; n++) @(posedge clk);
  endtask
  task run_row(input row_t r);
    logic [31:0] q;
    src <= 16'h0;
    nmi <= 1'b0;
    wb(1, `ADR_MODE, r.md, q);
    wb(1, `ADR_LEVELS, r.lv, q);
    wb(1, `ADR_CC, r.cc, q);
    wb(1, `ADR_XSTAT, r.xs, q);
    wb(1, `ADR_ENABLE, r.en, q);
    nacc = 0;
    hdone = 0;
    pushes.delete();
    src <= r.src;
    nmi <= r.nmi;
    wait_done();
    chk("accepts", nacc, r.acc);
    if (r.acc) begin
      chk("vector", av, r.vec);
      chk("handler", seen_pc, 16'hC000 | {6'h0, r.vec, 2'h0});
      chk("push count", pushes.size(), r.md == 2'h2 ? 3 : 2);
      chk("pushed pc", pushes[0], 16'h2468);
      chk("pushed cc", pushes[1][7:0], r.cc);
      if (r.md == 2'h2) chk("pushed ext", pushes[2][7:0], r.xs);
    end
    wb(0, r.md == 2'h2 ? `ADR_XSTAT : `ADR_CC, 0, q);
    chk("mask after", q[7:0], r.post);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  // main sequence
  initial begin
    logic [31:0] q;
    logic [7:0] ra[5] = '{`ADR_MODE, `ADR_LEVELS, `ADR_CC, `ADR_XSTAT, 8'h40};
    logic [31:0] rv[5] = '{`RST_MODE, `RST_LEVELS, `RST_CC, `RST_XSTAT, 32'h0};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    foreach (ra[k]) begin
      wb(0, ra[k], 0, q);
      chk("reset value", q, rv[k]);
    end
    wb(1, `ADR_MODE, 2, q);
    wb(1, `ADR_MODE, 1, q);
    wb(0, `ADR_MODE, 0, q);
    chk("mode kept", q, 2);
    wb(1, `ADR_LEVELS, 32'h33, q);
    wb(1, `ADR_XSTAT, 8'h83, q);
    wb(1, `ADR_ENABLE, 16'hFFFF, q);
    nacc = 0;
    src <= 16'h000A;
    repeat (20) @(posedge clk);
    chk("held pending", nacc, 0);
    hdone = 0;
    wb(1, `ADR_XSTAT, 8'h02, q);
    wait_done();
    chk("late accept", av, 8'h11);
    wb(0, `ADR_XSTAT, 0, q);
    chk("late mask", q, 32'h00000003);
    wb(0, `ADR_STATUS, 0, q);
    chk("still pending", q, 32'h0000000A);
    wb(0, `ADR_VECTOR, 0, q);
    chk("vector reg", q, {8'h00, 16'hC000 | {6'h00, 8'h11, 2'h0}, 8'h11});
    $display("hand tests done");
    give_verdict();
  end
endmodule
